// ### src/uefr_event_flags.sv
// USB event flag register with APB access, token status queue and interrupt.
//
// The APB interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps

module uefr_event_flags #(
   parameter int IDLE_CYCLES = uefr_pkg::IDLE_CYCLES
) (
   input  wire logic                          pclk,
   input  wire logic                          presetn,
   input  wire logic                          psel,
   input  wire logic                          penable,
   input  wire logic                          pwrite,
   input  wire logic [7:0]                    paddr,
   input  wire logic [31:0]                   pwdata,
   output logic [31:0]                        prdata,
   output logic                               pready,
   output logic                               pslverr,
   input  wire logic [1:0]                    line_state,
   input  wire logic                          bus_activity,
   input  wire logic                          stall_received,
   input  wire logic                          stall_sent,
   input  wire logic                          attach_detect,
   input  wire logic                          token_done,
   input  wire logic [uefr_pkg::STAT_W-1:0]   token_status,
   input  wire logic                          sof_received,
   input  wire logic                          sof_threshold,
   input  wire logic [uefr_pkg::ERR_W-1:0]    error_events,
   input  wire logic                          bus_reset_detect,
   input  wire logic                          detach_detect,
   output logic                               host_operation_enable,
   output logic                               usb_irq
);

   // ------------------------------------------------------------------------
   // Helper functions
   // ------------------------------------------------------------------------

   // Sticky update: a hardware set in the same cycle as a clear still lands.
   function automatic logic [7:0] sticky(input logic [7:0] cur,
                                         input logic [7:0] set,
                                         input logic [7:0] clr);
      sticky = set | (cur & ~clr);
   endfunction

   // Selects the mode-dependent source of a shared flag bit.
   function automatic logic by_mode(input logic host, input logic h, input logic d);
      by_mode = host ? h : d;
   endfunction

   // Widens a single bit to the queue counter width.
   function automatic logic [uefr_pkg::QCNT_W-1:0] cnt_bit(input logic b);
      cnt_bit = {{(uefr_pkg::QCNT_W-1){1'b0}}, b};
   endfunction

   // ------------------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------------------
   logic [uefr_pkg::FLAG_W-1:0]  flags;
   logic [uefr_pkg::FLAG_W-1:0]  mask;
   logic [uefr_pkg::ERR_W-1:0]   err_status;
   logic [uefr_pkg::ERR_W-1:0]   err_enable;
   logic                         error_summary_flag;
   logic [uefr_pkg::FLAG_W-1:0]  flag_view;
   logic [uefr_pkg::FLAG_W-1:0]  flag_set;
   logic [uefr_pkg::FLAG_W-1:0]  flag_clr;
   logic [uefr_pkg::ERR_W-1:0]   err_clr;
   logic [uefr_pkg::STAT_W-1:0]  queue [uefr_pkg::QUEUE_DEPTH];
   logic [uefr_pkg::QPTR_W-1:0]  q_head;
   logic [uefr_pkg::QPTR_W-1:0]  q_tail;
   logic [uefr_pkg::QCNT_W-1:0]  q_count;
   logic                         q_push;
   logic                         q_pop;
   logic                         pop_seen;
   logic                         quiet_done;
   logic                         resume_done;
   logic                         idle_done;
   logic                         resume_done_d;
   logic                         idle_done_d;
   logic                         attach_valid;
   logic                         setup_phase;
   logic                         wr_en;
   logic                         addr_ok;
   logic [31:0]                  next_prdata;

   // ------------------------------------------------------------------------
   // Line condition timers
   // ------------------------------------------------------------------------

   // Bus must have been silent for the quiet time before an attach is trusted.
   uefr_duration_timer #(
      .LIMIT (uefr_pkg::QUIET_CYCLES)
   ) u_quiet (
      .pclk    (pclk),
      .presetn (presetn),
      .run     (!bus_activity),
      .elapsed (quiet_done)
   );

   // K-state on the pair for the resume time.
   uefr_duration_timer #(
      .LIMIT (uefr_pkg::RESUME_CYCLES)
   ) u_resume (
      .pclk    (pclk),
      .presetn (presetn),
      .run     (line_state == uefr_pkg::LINE_K),
      .elapsed (resume_done)
   );

   // Idle (J) state held without a break for the idle time.
   uefr_duration_timer #(
      .LIMIT (IDLE_CYCLES)
   ) u_idle (
      .pclk    (pclk),
      .presetn (presetn),
      .run     (line_state == uefr_pkg::LINE_J),
      .elapsed (idle_done)
   );

   // Delayed copies so each long condition raises its flag only once per run.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         resume_done_d <= 1'b0;
         idle_done_d   <= 1'b0;
      end else begin
         resume_done_d <= resume_done;
         idle_done_d   <= idle_done;
      end
   end

   // ------------------------------------------------------------------------
   // APB decode
   // ------------------------------------------------------------------------

   // The slave answers with no wait state; pready comes from a flop set in setup.
   assign setup_phase = psel && !penable;
   assign wr_en       = psel && penable && pready && pwrite;
   assign addr_ok     = (paddr == uefr_pkg::OFS_FLAGS)      || (paddr == uefr_pkg::OFS_MASK)       ||
                        (paddr == uefr_pkg::OFS_ERR_STATUS) || (paddr == uefr_pkg::OFS_ERR_ENABLE) ||
                        (paddr == uefr_pkg::OFS_XFER_STAT)  || (paddr == uefr_pkg::OFS_CONTROL);

   // ------------------------------------------------------------------------
   // Event set and clear vectors
   // ------------------------------------------------------------------------
   assign attach_valid = host_operation_enable && quiet_done &&
                         (line_state != uefr_pkg::LINE_SE0);

   always_comb begin
      flag_set = uefr_pkg::FLAGS_RST;
      flag_set[uefr_pkg::BIT_STALL]  = by_mode(host_operation_enable,
                                               stall_received, stall_sent);
      flag_set[uefr_pkg::BIT_ATTACH] = attach_detect && attach_valid;
      flag_set[uefr_pkg::BIT_RESUME] = resume_done && !resume_done_d;
      flag_set[uefr_pkg::BIT_IDLE]   = idle_done && !idle_done_d;
      flag_set[uefr_pkg::BIT_TOKEN]  = token_done || (pop_seen && (q_count != '0));
      flag_set[uefr_pkg::BIT_FRAME]  = by_mode(host_operation_enable,
                                               sof_threshold, sof_received);
      flag_set[uefr_pkg::BIT_RESET]  = by_mode(host_operation_enable,
                                               detach_detect, bus_reset_detect);
   end

   // Only a write of one clears; the summary bit is never cleared from the bus.
   always_comb begin
      flag_clr = uefr_pkg::FLAGS_RST;
      if (wr_en && (paddr == uefr_pkg::OFS_FLAGS)) begin
         flag_clr = pwdata[uefr_pkg::FLAG_W-1:0];
      end
      flag_clr[uefr_pkg::BIT_ERRSUM] = 1'b0;
   end

   always_comb begin
      err_clr = uefr_pkg::ERR_RST;
      if (wr_en && (paddr == uefr_pkg::OFS_ERR_STATUS)) begin
         err_clr = pwdata[uefr_pkg::ERR_W-1:0];
      end
   end

   // ------------------------------------------------------------------------
   // Flag storage
   // ------------------------------------------------------------------------

   // Sticky flags; bit 1 of this store is unused, the summary lives below.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flags <= uefr_pkg::FLAGS_RST;
      end else begin
         flags <= sticky(flags, flag_set, flag_clr);
      end
   end

   // Individual error conditions, write one to clear, set wins.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         err_status <= uefr_pkg::ERR_RST;
      end else begin
         err_status <= sticky(err_status, error_events, err_clr);
      end
   end

   // Summary follows only the enabled error conditions and cannot be written.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         error_summary_flag <= 1'b0;
      end else begin
         error_summary_flag <= |(err_status & err_enable);
      end
   end

   // Software-facing view of the flags with the summary in its place.
   always_comb begin
      flag_view = flags;
      flag_view[uefr_pkg::BIT_ERRSUM] = error_summary_flag;
   end

   // ------------------------------------------------------------------------
   // Writable configuration registers
   // ------------------------------------------------------------------------

   // Mask, error enable and mode. Mode changes take effect on the next cycle.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask                  <= uefr_pkg::MASK_RST;
         err_enable            <= uefr_pkg::ERR_RST;
         host_operation_enable <= 1'b0;
      end else if (wr_en) begin
         case (paddr)
            uefr_pkg::OFS_MASK: begin
               mask <= pwdata[uefr_pkg::FLAG_W-1:0];
            end
            uefr_pkg::OFS_ERR_ENABLE: begin
               err_enable <= pwdata[uefr_pkg::ERR_W-1:0];
            end
            uefr_pkg::OFS_CONTROL: begin
               host_operation_enable <= pwdata[uefr_pkg::BIT_HOST_EN];
            end
            default: begin
               mask <= mask;
            end
         endcase
      end
   end

   // ------------------------------------------------------------------------
   // Token status queue
   // ------------------------------------------------------------------------

   // A completion while the queue is full loses its status word; the flag still sets.
   assign q_push = token_done && (q_count != uefr_pkg::QCNT_W'(uefr_pkg::QUEUE_DEPTH));
   assign q_pop  = flags[uefr_pkg::BIT_TOKEN] && flag_clr[uefr_pkg::BIT_TOKEN] &&
                   !flag_set[uefr_pkg::BIT_TOKEN] && (q_count != '0);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q_head  <= '0;
         q_tail  <= '0;
         q_count <= '0;
      end else begin
         if (q_push) begin
            q_tail <= q_tail + 1'b1;
         end
         if (q_pop) begin
            q_head <= q_head + 1'b1;
         end
         q_count <= q_count + cnt_bit(q_push) - cnt_bit(q_pop);
      end
   end

   // Status words are not reset; only entries below the count are ever read.
   always_ff @(posedge pclk) begin
      if (q_push) begin
         queue[q_tail] <= token_status;
      end
   end

   // After a pop the flag comes back if more completions wait in the queue.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pop_seen <= 1'b0;
      end else begin
         pop_seen <= q_pop;
      end
   end

   // ------------------------------------------------------------------------
   // APB read data and response
   // ------------------------------------------------------------------------
   always_comb begin
      next_prdata = uefr_pkg::WORD_ZERO;
      case (paddr)
         uefr_pkg::OFS_FLAGS: begin
            next_prdata[uefr_pkg::FLAG_W-1:0] = flag_view;
         end
         uefr_pkg::OFS_MASK: begin
            next_prdata[uefr_pkg::FLAG_W-1:0] = mask;
         end
         uefr_pkg::OFS_ERR_STATUS: begin
            next_prdata[uefr_pkg::ERR_W-1:0] = err_status;
         end
         uefr_pkg::OFS_ERR_ENABLE: begin
            next_prdata[uefr_pkg::ERR_W-1:0] = err_enable;
         end
         uefr_pkg::OFS_XFER_STAT: begin
            if (q_count != '0) begin
               next_prdata[uefr_pkg::STAT_W-1:0] = queue[q_head];
            end
         end
         uefr_pkg::OFS_CONTROL: begin
            next_prdata[uefr_pkg::BIT_HOST_EN] = host_operation_enable;
         end
         default: begin
            next_prdata = uefr_pkg::WORD_ZERO;
         end
      endcase
   end

   // Read data is captured in setup, so it reflects state one cycle before the access edge.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= uefr_pkg::WORD_ZERO;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= setup_phase;
         pslverr <= setup_phase && !addr_ok;
         if (setup_phase && !pwrite) begin
            prdata <= next_prdata;
         end
      end
   end

   // ------------------------------------------------------------------------
   // Interrupt
   // ------------------------------------------------------------------------

   // Level output; software should leave the resume mask clear unless suspended.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         usb_irq <= 1'b0;
      end else begin
         usb_irq <= |(flag_view & mask);
      end
   end

endmodule

// ### src/uefr_pkg.sv
// Register map, field layout and timing constants of the USB event flag block.
package uefr_pkg;

   // --------------------
   // Register byte offsets
   // --------------------
   localparam logic [7:0] OFS_FLAGS      = 8'h00;
   localparam logic [7:0] OFS_MASK       = 8'h04;
   localparam logic [7:0] OFS_ERR_STATUS = 8'h08;
   localparam logic [7:0] OFS_ERR_ENABLE = 8'h0C;
   localparam logic [7:0] OFS_XFER_STAT  = 8'h10;
   localparam logic [7:0] OFS_CONTROL    = 8'h14;

   // --------------------
   // Flag bit positions and widths
   // --------------------
   localparam int FLAG_W       = 8;
   localparam int ERR_W        = 8;
   localparam int STAT_W       = 8;
   localparam int BIT_STALL    = 7;
   localparam int BIT_ATTACH   = 6;
   localparam int BIT_RESUME   = 5;
   localparam int BIT_IDLE     = 4;
   localparam int BIT_TOKEN    = 3;
   localparam int BIT_FRAME    = 2;
   localparam int BIT_ERRSUM   = 1;
   localparam int BIT_RESET    = 0;
   localparam int BIT_HOST_EN  = 0;

   // --------------------
   // Reset values
   // --------------------
   localparam logic [FLAG_W-1:0] FLAGS_RST = 8'h00;
   localparam logic [FLAG_W-1:0] MASK_RST  = 8'h00;
   localparam logic [ERR_W-1:0]  ERR_RST   = 8'h00;
   localparam logic [STAT_W-1:0] STAT_RST  = 8'h00;
   localparam logic [31:0]       WORD_ZERO = 32'h00000000;

   // --------------------
   // Line states seen on the differential pair
   // --------------------
   localparam logic [1:0] LINE_SE0 = 2'h0;
   localparam logic [1:0] LINE_J   = 2'h1;
   localparam logic [1:0] LINE_K   = 2'h2;

   // --------------------
   // Token status queue
   // --------------------
   localparam int QUEUE_DEPTH = 4;
   localparam int QPTR_W      = 2;
   localparam int QCNT_W      = 3;

   // --------------------
   // Timing
   // --------------------
   localparam real CLK_MHZ         = 200.0;
   localparam real QUIET_TIME_US   = 2.5;
   localparam real RESUME_K_US     = 2.5;
   localparam real IDLE_TIME_MS    = 3.0;
   localparam int  TIMER_W         = 20;
   localparam int  QUIET_CYCLES    = int'($ceil(QUIET_TIME_US * CLK_MHZ));
   localparam int  RESUME_CYCLES   = int'($ceil(RESUME_K_US * CLK_MHZ));
   localparam int  IDLE_CYCLES     = int'($ceil(IDLE_TIME_MS * 1000.0 * CLK_MHZ));

endpackage

// ### src/uefr_duration_timer.sv
// Timer that reports an unbroken run of a condition of a given length.
`timescale 1ns/1ps
module uefr_duration_timer #(
   parameter int LIMIT = 1
) (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic run,
   output logic      elapsed
);

   localparam logic [uefr_pkg::TIMER_W-1:0] LIM_W  = uefr_pkg::TIMER_W'(LIMIT);
   localparam logic [uefr_pkg::TIMER_W-1:0] LAST_W = uefr_pkg::TIMER_W'(LIMIT - 1);

   logic [uefr_pkg::TIMER_W-1:0] count;

   // The count restarts whenever the condition drops, so only an unbroken run counts.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count <= '0;
      end else if (!run) begin
         count <= '0;
      end else if (count != LIM_W) begin
         count <= count + 1'b1;
      end
   end

   // High from the cycle after the LIMIT-th consecutive run cycle until run drops.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         elapsed <= 1'b0;
      end else begin
         elapsed <= run && (count >= LAST_W);
      end
   end

endmodule

// ### testbench/uefr_event_flags_monitor.sv
// Checker of the USB event flag block, bound to the ports of its top module.
`timescale 1ns/1ps
module uefr_event_flags_monitor #(
   parameter int IDLE_CYCLES = 50
) (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic [1:0]  line_state,
   input wire logic        stall_received,
   input wire logic        host_operation_enable,
   input wire logic        usb_irq
);
   logic [7:0] mask_q;
   logic [1:0] last_line;
   int         run_cnt;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // ----------------
   // Helper state
   // ----------------
   // Shadow of the interrupt mask register.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask_q <= 8'h00;
      end else if (psel && penable && pready && pwrite && paddr == uefr_pkg::OFS_MASK) begin
         mask_q <= pwdata[7:0];
      end
   end

   // Length of the current line state run; cheaper than a long repetition.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         last_line <= 2'h0;
         run_cnt   <= 0;
      end else begin
         last_line <= line_state;
         run_cnt   <= (line_state == last_line) ? run_cnt + 1 : 1;
      end
   end

   // ----------------
   // Properties
   // ----------------
   property p_rdy; psel && !penable |=> pready; endproperty
   a_rdy: assert property (p_rdy) else $error("pready missing after setup");
   property p_err; psel && !penable && paddr > uefr_pkg::OFS_CONTROL |=> pslverr; endproperty
   a_err: assert property (p_err) else $error("unmapped access not flagged");
   property p_upper; pready && !pwrite |-> prdata[31:8] == 24'h000000; endproperty
   a_upper: assert property (p_upper) else $error("upper read bits not zero");
   property p_rst; $rose(presetn) |-> prdata == 32'h00000000 && !usb_irq && !host_operation_enable; endproperty
   a_rst: assert property (p_rst) else $error("outputs not zero after reset");
   property p_fall; $fell(usb_irq) |-> $past(pwrite && pready, 2) || $past(pwrite && pready, 3); endproperty
   a_fall: assert property (p_fall) else $error("interrupt dropped without a write");
   property p_stall; stall_received && host_operation_enable && mask_q[7] |-> ##2 usb_irq; endproperty
   a_stall: assert property (p_stall) else $error("received stall raised no interrupt");
   property p_resume; line_state == uefr_pkg::LINE_K && run_cnt == 500 && mask_q[5] |-> ##[1:5] usb_irq; endproperty
   a_resume: assert property (p_resume) else $error("long K state raised no interrupt");
   property p_idle; line_state == uefr_pkg::LINE_J && run_cnt == IDLE_CYCLES && mask_q[4] |-> ##[1:5] usb_irq;
   endproperty
   a_idle: assert property (p_idle) else $error("long idle raised no interrupt");

   c_irq: cover property ($rose(usb_irq));
   c_err: cover property (pslverr);
   c_stall: cover property (stall_received && host_operation_enable);
endmodule

bind uefr_event_flags uefr_event_flags_monitor #(.IDLE_CYCLES(IDLE_CYCLES)) i_uefr_event_flags_monitor (
   .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .line_state,
   .stall_received, .host_operation_enable, .usb_irq);

// ### testbench/uefr_link_model.sv
// Behavioural model of the far side of the USB link: line states and event pulses.
`timescale 1ns/1ps
module uefr_link_model (
   input  wire logic  pclk,
   output logic [1:0] line_state = uefr_pkg::LINE_SE0,
   output logic       bus_activity = 1'b0,
   output logic       stall_received,
   output logic       stall_sent,
   output logic       attach_detect,
   output logic       token_done,
   output logic [7:0] token_status,
   output logic       sof_received,
   output logic       sof_threshold,
   output logic [7:0] error_events,
   output logic       bus_reset_detect,
   output logic       detach_detect
);
   logic [8:0] pls = 9'h000;
   logic [7:0] val = 8'h00;

   // Events are one-cycle pulses; the status byte is inverted outside a token pulse.
   assign {detach_detect, bus_reset_detect, sof_threshold, sof_received} = {pls[8:7], pls[5:4]};
   assign {token_done, attach_detect, stall_sent, stall_received} = pls[3:0];
   assign error_events = pls[6] ? val : 8'h00;
   assign token_status = pls[3] ? val : ~val;

   // Pulse event n for one cycle, carrying v as status or error bits.
   task automatic fire(input int n, input logic [7:0] v);
      @(posedge pclk);
      pls <= 9'h001 << n;
      val <= v;
      @(posedge pclk);
      pls <= 9'h000;
   endtask

   // Hold a line state and activity level for n cycles; it stays until changed.
   task automatic hold(input logic [1:0] s, input logic a, input int n);
      @(posedge pclk);
      line_state   <= s;
      bus_activity <= a;
      repeat (n) @(posedge pclk);
   endtask
endmodule

// ### testbench/tb_top.sv
// Self-checking testbench of the USB event flag block.
`timescale 1ns/1ps
module tb_top;
   localparam logic [7:0] AF = uefr_pkg::OFS_FLAGS, AM = uefr_pkg::OFS_MASK, AE = uefr_pkg::OFS_ERR_STATUS;
   localparam logic [7:0] AN = uefr_pkg::OFS_ERR_ENABLE, AS = uefr_pkg::OFS_XFER_STAT, AC = uefr_pkg::OFS_CONTROL;
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h00000000, prdata, rd;
   logic        pready, pslverr, last_err, host_operation_enable, usb_irq, bus_activity;
   logic        stall_received, stall_sent, attach_detect, token_done, sof_received, sof_threshold;
   logic        bus_reset_detect, detach_detect;
   logic [1:0]  line_state;
   logic [7:0]  token_status, error_events;
   logic [7:0]  ts [3] = '{8'hA1, 8'hB2, 8'hC3};
   int          miscompares = 0, samples_checked = 0;

   // A short idle time keeps the run brief; every expectation follows from it.
   uefr_event_flags #(.IDLE_CYCLES(50)) i_uefr_event_flags (.pclk, .presetn, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .line_state, .bus_activity, .stall_received, .stall_sent,
      .attach_detect, .token_done, .token_status, .sof_received, .sof_threshold, .error_events,
      .bus_reset_detect, .detach_detect, .host_operation_enable, .usb_irq);
   uefr_link_model i_uefr_link_model (.pclk, .line_state, .bus_activity, .stall_received, .stall_sent,
      .attach_detect, .token_done, .token_status, .sof_received, .sof_threshold, .error_events,
      .bus_reset_detect, .detach_detect);

   initial forever #2.5 pclk = ~pclk;

   // ----------------
   // Shared tasks
   // ----------------
   task automatic conclude;
      if (miscompares == 0 && samples_checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // One APB transfer; outputs are read right after the edge, before the design's updates land.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd       = prdata;
      last_err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h00000000);
      chk(rd, e);
   endtask

   task automatic ichk(input logic e);
      repeat (3) @(posedge pclk);
      @(negedge pclk);
      chk(32'(usb_irq), 32'(e));
   endtask

   // ----------------
   // Scenarios
   // ----------------
   task automatic t_reset;
      for (int a = 0; a < 24; a += 4) rchk(8'(a), 32'h00000000);
      wr(8'h40, 32'hFFFFFFFF);
      chk({31'h00000000, last_err}, 32'h00000001);
      rchk(8'h40, 32'h00000000);
   endtask

   // Fires the other mode's sources first, which must be ignored, then this mode's own.
   task automatic t_mode(input logic h);
      wr(AC, {31'h0, h});
      for (int p = 0; p < 2; p++) begin
         for (int n = 0; n < 9; n++) begin
            if (n != 2 && n != 3 && n != 6 && ((n % 3 == 1) != h) == (p == 1)) i_uefr_link_model.fire(n, 8'h00);
         end
         rchk(AF, (p == 1) ? 32'h85 : 32'h0);
      end
      ichk(1'b1);
      wr(AF, 32'h00000000);
      rchk(AF, 32'h00000085);
      wr(AF, 32'h00000080);
      rchk(AF, 32'h00000005);
      wr(AF, 32'h00000005);
      rchk(AF, 32'h00000000);
      ichk(1'b0);
   endtask

   // A stall arrives on the very edge that the clearing write lands.
   task automatic t_win;
      i_uefr_link_model.fire(0, 8'h00);
      fork
         wr(AF, 32'h00000080);
         begin
            @(posedge pclk);
            i_uefr_link_model.fire(0, 8'h00);
         end
      join
      rchk(AF, 32'h00000080);
      wr(AF, 32'h00000080);
   endtask

   task automatic t_link;
      i_uefr_link_model.hold(uefr_pkg::LINE_J, 1'b1, 20);
      i_uefr_link_model.fire(2, 8'h00);
      i_uefr_link_model.hold(uefr_pkg::LINE_SE0, 1'b0, 510);
      i_uefr_link_model.fire(2, 8'h00);
      rchk(AF, 32'h00000000);
      i_uefr_link_model.hold(uefr_pkg::LINE_J, 1'b0, 510);
      i_uefr_link_model.fire(2, 8'h00);
      rchk(AF, 32'h00000050);
      wr(AF, 32'h00000050);
      wr(AM, 32'h000000FF);
      i_uefr_link_model.hold(uefr_pkg::LINE_K, 1'b1, 400);
      i_uefr_link_model.hold(uefr_pkg::LINE_SE0, 1'b0, 1);
      rchk(AF, 32'h00000000);
      i_uefr_link_model.hold(uefr_pkg::LINE_K, 1'b1, 510);
      i_uefr_link_model.hold(uefr_pkg::LINE_SE0, 1'b0, 1);
      rchk(AF, 32'h00000020);
      wr(AF, 32'h00000020);
   endtask

   task automatic t_token;
      for (int i = 0; i < 3; i++) i_uefr_link_model.fire(3, ts[i]);
      for (int i = 0; i < 4; i++) begin
         rchk(AS, (i < 3) ? {24'h000000, ts[i]} : 32'h00000000);
         rchk(AF, (i < 3) ? 32'h00000008 : 32'h00000000);
         wr(AF, 32'h00000008);
      end
   endtask

   task automatic t_error;
      i_uefr_link_model.fire(6, 8'h01);
      rchk(AF, 32'h00000000);
      wr(AN, 32'h00000001);
      rchk(AF, 32'h00000002);
      wr(AF, 32'h00000002);
      rchk(AF, 32'h00000002);
      wr(AE, 32'h00000001);
      rchk(AF, 32'h00000000);
   endtask

   task automatic t_irq;
      i_uefr_link_model.fire(0, 8'h00);
      wr(AM, 32'h00000000);
      ichk(1'b0);
      wr(AM, 32'h00000080);
      ichk(1'b1);
      wr(AF, 32'h00000080);
      ichk(1'b0);
   endtask

   // Main sequence: reset for 10 cycles, then every scenario in turn.
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      wr(AM, 32'h000000DF);
      t_mode(1'b0);
      t_mode(1'b1);
      t_win();
      t_link();
      t_token();
      t_error();
      t_irq();
      conclude();
   end

   // Watchdog: the scenarios need about 2200 cycles, so 20000 means a hang.
   initial begin
      repeat (20000) @(posedge pclk);
      miscompares++;
      conclude();
   end
endmodule
